//--- dv/watchdog_led_battery_ports_tb.sv
/*
  Self-checking bench for the watchdog, lamp, battery and window port block.
  Assumes the block alone on a 25 MHz clock; the bench drives every port itself.
*/
`timescale 1ns/1ps
module watchdog_led_battery_ports_tb;
    import wdt_ports_pkg::*;
    localparam int TICK = 4;
    localparam int AW = 6;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [15:0] io_addr_i = 16'h0000;
    logic io_rd_i = 1'b0;
    logic io_wr_i = 1'b0;
    logic [15:0] io_wdata_i = 16'h0000;
    logic [15:0] io_rdata_o;
    logic io_rvalid_o;
    logic mem_sel_i = 1'b0;
    logic [AW-1:0] mem_addr_i = '0;
    logic mem_rd_i = 1'b0;
    logic mem_wr_i = 1'b0;
    logic [7:0] mem_wdata_i = 8'h00;
    logic [7:0] mem_rdata_o;
    logic mem_rvalid_o;
    logic [1:0] battery_level_i = 2'b00;
    logic alarm_o, lamp_o, g1, y1, r2, y2, r3, y3;
    int err_count = 0;
    int samples_checked = 0;
    int seed = 27;
    logic [15:0] rd_val;
    logic [15:0] rnd;
    logic [7:0] mem_img [0:7];

    watchdog_led_battery_ports #(.TICK_CYC(TICK), .NVM_AW(AW)) dut_u (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .io_addr_i(io_addr_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i),
        .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
        .mem_sel_i(mem_sel_i), .mem_addr_i(mem_addr_i), .mem_rd_i(mem_rd_i),
        .mem_wr_i(mem_wr_i), .mem_wdata_i(mem_wdata_i), .mem_rdata_o(mem_rdata_o),
        .mem_rvalid_o(mem_rvalid_o), .battery_level_i(battery_level_i),
        .timeout_monitor_alarm_o(alarm_o), .timeout_monitor_lamp_o(lamp_o),
        .first_user_lamp_green_o(g1), .first_user_lamp_yellow_o(y1),
        .second_user_lamp_red_o(r2), .second_user_lamp_yellow_o(y2),
        .third_user_lamp_red_o(r3), .third_user_lamp_yellow_o(y3)
    );

    always #20 ref_clk_i = ~ref_clk_i;

    task automatic end_sim();
        $display("compares %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic io_wr(input logic [15:0] addr, input logic [15:0] data);
        io_addr_i = addr;
        io_wdata_i = data;
        io_wr_i = 1'b1;
        @(posedge ref_clk_i);
        #2 io_wr_i = 1'b0;
    endtask

    task automatic io_rd(input logic [15:0] addr, output logic [15:0] data);
        io_addr_i = addr;
        io_rd_i = 1'b1;
        @(posedge ref_clk_i);
        #2 io_rd_i = 1'b0;
        check("rvalid", {15'h0, io_rvalid_o}, 16'h0001);
        data = io_rdata_o;
        @(posedge ref_clk_i);
        #2;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #2;
    endtask

    // expected lamp pins {g1,y1,r2,y2,r3,y3} for a lamp register value
    function automatic logic [15:0] lamps_exp(input logic [15:0] v);
        return {10'h0, ~v[15], v[15] & ~v[7], ~v[14], v[14] & ~v[6], ~v[13], v[13] & ~v[5]};
    endfunction

    // expiry time in clock cycles for a time base and scaler setting
    function automatic int limit_cyc(input logic macro, input logic [2:0] sc);
        int std_ms [8] = '{94, 210, 340, 460, 590, 710, 840, 960};
        int mac_s [8] = '{2, 4, 6, 8, 16, 32, 48, 64};
        return (macro ? mac_s[sc] * 1000 : std_ms[sc]) * TICK;
    endfunction

    // enable with a setting, look just before and just after expiry, then clear
    task automatic expire_case(input logic macro, input logic [2:0] sc);
        int l;
        l = limit_cyc(macro, sc);
        io_wr(ADDR_WDT_CTRL, {8'h00, 2'b00, sc, 1'b1, macro, 1'b1});
        wait_cyc(l - 4);
        check("alarm early", {15'h0, alarm_o}, 16'h0000);
        wait_cyc(8);
        check("alarm late", {15'h0, alarm_o}, 16'h0001);
        io_rd(ADDR_WDT_CTRL, rd_val);
        check("err flag", rd_val, {8'h00, 2'b10, sc, 1'b1, macro, 1'b1});
        io_wr(ADDR_WDT_CTRL, 16'h0084);
        check("alarm clr", {15'h0, alarm_o}, 16'h0000);
        io_rd(ADDR_WDT_CTRL, rd_val);
        check("flag clr", rd_val, 16'h0004);
    endtask

    initial begin
        // tests need about 43k cycles; allow 60k
        #2400000;
        err_count++;
        $display("[ERR] watchdog expired");
        end_sim();
    end

    initial begin
        rnd = 16'($random(seed));
        wait_cyc(6);
        sys_rst_i = 1'b0;
        wait_cyc(1);
        io_rd(ADDR_WDT_CTRL, rd_val);
        check("ctrl reset", rd_val, 16'h0004);
        io_rd(ADDR_LAMPS, rd_val);
        check("lamp reset", rd_val, 16'hE0E0);
        check("lamps dark", {10'h0, g1, y1, r2, y2, r3, y3}, 16'h0000);
        check("alarm reset", {14'h0, alarm_o, lamp_o}, 16'h0000);
        $display("test reset done");

        for (int i = 0; i < 20; i++) begin
            rnd = (i < 8) ? {i[2:0], 5'h1F, i[2:0], 5'h00} : 16'($random(seed));
            io_wr(ADDR_LAMPS, rnd);
            check("lamp pins", {10'h0, g1, y1, r2, y2, r3, y3}, lamps_exp(rnd));
            io_rd(ADDR_LAMPS, rd_val);
            check("lamp rdback", rd_val, rnd);
        end
        $display("test lamps done");

        for (int i = 0; i < 8; i++) begin
            rnd = (16'($random(seed)) & 16'h007A) | 16'h0004;
            io_wr(ADDR_WDT_CTRL, rnd | 16'hFF00);
            check("red lamp", {15'h0, lamp_o}, {15'h0, rnd[6]});
            io_rd(ADDR_WDT_CTRL, rd_val);
            check("ctrl rdback", rd_val, rnd);
        end
        io_wr(ADDR_WDT_CTRL, 16'h0004);
        wait_cyc(limit_cyc(1'b0, 3'd0) + 20);
        check("disabled", {15'h0, alarm_o}, 16'h0000);
        $display("test control done");

        io_wr(ADDR_WDT_CTRL, 16'h0005);
        for (int i = 0; i < 5; i++) begin
            wait_cyc(limit_cyc(1'b0, 3'd0) - 60);
            io_rd(ADDR_WDT_TRIG, rd_val);
        end
        check("retrig", {15'h0, alarm_o}, 16'h0000);
        check("trig data", rd_val, 16'h0000);
        io_wr(ADDR_WDT_CTRL, 16'h0004);
        wait_cyc(1);
        for (int s = 0; s < 8; s++) begin
            expire_case(1'b0, 3'(s));
        end
        expire_case(1'b1, 3'd0);
        expire_case(1'b1, 3'd1);
        $display("test watchdog done");

        // monitoring is taken as switched on elsewhere before these reads
        for (int i = 0; i < 6; i++) begin
            battery_level_i = (i < 3) ? 2'((i * i + i) / 2) : 2'($random(seed));
            if (battery_level_i == 2'b10) begin
                battery_level_i = 2'b11;
            end
            io_wr(ADDR_BATTERY, 16'hFFFF);
            wait_cyc(3);
            io_rd(ADDR_BATTERY, rd_val);
            check("battery", rd_val, {8'h00, battery_level_i, 6'h00});
        end
        io_rd(16'h1234, rd_val);
        check("unmapped", rd_val, 16'h0000);
        $display("test battery done");

        mem_sel_i = 1'b1;
        mem_wr_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            mem_img[i] = 8'($random(seed));
            mem_addr_i = AW'(i * 9);
            mem_wdata_i = mem_img[i];
            wait_cyc(1);
        end
        mem_wr_i = 1'b0;
        for (int i = 0; i < 8; i++) begin
            mem_addr_i = AW'(i * 9);
            mem_rd_i = 1'b1;
            wait_cyc(1);
            mem_rd_i = 1'b0;
            check("mem valid", {15'h0, mem_rvalid_o}, 16'h0001);
            check("mem data", {8'h00, mem_rdata_o}, {8'h00, mem_img[i]});
            wait_cyc(1);
        end
        mem_sel_i = 1'b0;
        $display("test window done");
        end_sim();
    end
endmodule

//--- hw/watchdog_led_battery_ports.sv
/*
  Host I/O port block: watchdog control and trigger, user lamps, battery status,
  and a retained memory window.
  Assumes the host bus delivers one-cycle read/write strobes on the system clock,
  and that window base decoding is done outside and arrives as a select.
*/
`timescale 1ns/1ps
module watchdog_led_battery_ports #(
    parameter int TICK_CYC = wdt_ports_pkg::TICK_CYCLES,
    parameter int NVM_AW = wdt_ports_pkg::NVM_ADDR_W
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // host I/O port access
    input wire logic [15:0] io_addr_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [15:0] io_wdata_i,
    output logic [15:0] io_rdata_o,
    output logic io_rvalid_o,
    // retained memory window
    input wire logic mem_sel_i,
    input wire logic [NVM_AW-1:0] mem_addr_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o,
    output logic mem_rvalid_o,
    // battery sense pins
    input wire logic [1:0] battery_level_i,
    // watchdog outputs
    output logic timeout_monitor_alarm_o,
    output logic timeout_monitor_lamp_o,
    // user lamps
    output logic first_user_lamp_green_o,
    output logic first_user_lamp_yellow_o,
    output logic second_user_lamp_red_o,
    output logic second_user_lamp_yellow_o,
    output logic third_user_lamp_red_o,
    output logic third_user_lamp_yellow_o
);
    import wdt_ports_pkg::*;

    localparam int NVM_DEPTH = 1 << NVM_AW;

    // address decode
    wire hit_ctrl = (io_addr_i == ADDR_WDT_CTRL);
    wire hit_trig = (io_addr_i == ADDR_WDT_TRIG);
    wire hit_batt = (io_addr_i == ADDR_BATTERY);
    wire hit_lamp = (io_addr_i == ADDR_LAMPS);
    wire wr_ctrl = io_wr_i && hit_ctrl;
    wire wr_lamp = io_wr_i && hit_lamp;
    wire trig_rd = io_rd_i && hit_trig;

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic err_reg;
    logic err_next;
    logic [15:0] lamp_reg;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic rvalid_reg;
    logic [1:0] batt_meta_reg;
    logic [1:0] batt_sync_reg;
    logic [7:0] nvm_mem [NVM_DEPTH];
    logic [7:0] mem_rdata_reg;
    logic mem_rvalid_reg;

    wd_timer_if tmr ();

    wd_countdown #(
        .TICK_CYC(TICK_CYC)
    ) u_countdown (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .tmr(tmr)
    );

    // control register: bits 6..0 stored, bit 7 is the sticky error flag
    assign ctrl_next = wr_ctrl ? (io_wdata_i[7:0] & CTRL_STORE_MASK) : ctrl_reg;

    // a fresh expiry wins over a clear in the same cycle
    wire err_clear = wr_ctrl && io_wdata_i[CTRL_ERR_BIT];
    assign err_next = tmr.expired ? 1'b1 : (err_clear ? 1'b0 : err_reg);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= CTRL_RESET;
            err_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            err_reg <= err_next;
        end
    end

    // countdown control
    wire wd_enabled = ctrl_reg[CTRL_EN_BIT];
    wire wd_macro = ctrl_reg[CTRL_MACRO_BIT];
    wire [2:0] wd_scale = ctrl_reg[CTRL_SCALE_HI:CTRL_SCALE_LO];
    assign tmr.run = wd_enabled;
    assign tmr.limit_ms = timeout_ms(wd_macro, wd_scale);
    // enabling or reprogramming restarts too, so a stale count never fires early
    assign tmr.restart = trig_rd || wr_ctrl;

    assign timeout_monitor_alarm_o = err_reg;
    assign timeout_monitor_lamp_o = ctrl_reg[CTRL_LAMP_BIT];

    // lamp register, reserved bits kept as plain storage
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lamp_reg <= LAMP_RESET;
        end else if (wr_lamp) begin
            lamp_reg <= io_wdata_i;
        end
    end

    assign first_user_lamp_green_o = !lamp_reg[LAMP1_HI];
    assign first_user_lamp_yellow_o = lamp_reg[LAMP1_HI] && !lamp_reg[LAMP1_LO];
    assign second_user_lamp_red_o = !lamp_reg[LAMP2_HI];
    assign second_user_lamp_yellow_o = lamp_reg[LAMP2_HI] && !lamp_reg[LAMP2_LO];
    assign third_user_lamp_red_o = !lamp_reg[LAMP3_HI];
    assign third_user_lamp_yellow_o = lamp_reg[LAMP3_HI] && !lamp_reg[LAMP3_LO];

    // battery sense crosses in through two flops; no write path exists
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            batt_meta_reg <= 2'h0;
            batt_sync_reg <= 2'h0;
        end else begin
            batt_meta_reg <= battery_level_i;
            batt_sync_reg <= batt_meta_reg;
        end
    end

    wire [7:0] batt_word = {batt_sync_reg, 6'h00};
    wire [7:0] ctrl_word = {err_reg, ctrl_reg[CTRL_LAMP_BIT:CTRL_EN_BIT]};

    // read mux; the trigger port and unmapped addresses return zero
    always_comb begin
        rdata_next = 16'h0000;
        if (hit_ctrl) begin
            rdata_next = {8'h00, ctrl_word};
        end else if (hit_batt) begin
            rdata_next = {8'h00, batt_word};
        end else if (hit_lamp) begin
            rdata_next = lamp_reg;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= io_rd_i;
            if (io_rd_i) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign io_rdata_o = rdata_reg;
    assign io_rvalid_o = rvalid_reg;

    // retained memory window; the write port only loads content
    always_ff @(posedge ref_clk_i) begin
        if (mem_sel_i && mem_wr_i) begin
            nvm_mem[mem_addr_i] <= mem_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mem_rdata_reg <= 8'h00;
            mem_rvalid_reg <= 1'b0;
        end else begin
            mem_rvalid_reg <= mem_sel_i && mem_rd_i;
            if (mem_sel_i && mem_rd_i) begin
                mem_rdata_reg <= nvm_mem[mem_addr_i];
            end
        end
    end

    assign mem_rdata_o = mem_rdata_reg;
    assign mem_rvalid_o = mem_rvalid_reg;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence trig_read_s;
        io_rd_i && io_addr_i == ADDR_WDT_TRIG;
    endsequence

    sequence count_zero_s;
        tmr.elapsed_ms == 16'h0000;
    endsequence

    sequence err_clear_s;
        io_wr_i && io_addr_i == ADDR_WDT_CTRL && io_wdata_i[CTRL_ERR_BIT] && !tmr.expired;
    endsequence

    sequence mem_read_s;
        mem_sel_i && mem_rd_i;
    endsequence

    trig_restart_a: assert property (trig_read_s |=> count_zero_s)
        else $error("trigger read did not restart the countdown");

    disabled_idle_a: assert property (!ctrl_reg[CTRL_EN_BIT] |=> count_zero_s ##0 !tmr.expired)
        else $error("disabled watchdog kept counting");

    limit_table_a: assert property (tmr.limit_ms == (ctrl_reg[CTRL_MACRO_BIT]
            ? MACRO_S[ctrl_reg[CTRL_SCALE_HI:CTRL_SCALE_LO]] * MS_PER_S
            : STD_MS[ctrl_reg[CTRL_SCALE_HI:CTRL_SCALE_LO]]))
        else $error("timeout limit does not match mode and scaler");

    fire_sticky_a: assert property (tmr.expired
            |=> timeout_monitor_alarm_o && ctrl_word[CTRL_ERR_BIT])
        else $error("expiry did not raise the alarm");

    flag_clear_a: assert property (err_clear_s |=> !err_reg ##1 (err_reg == $past(tmr.expired)))
        else $error("error flag not cleared by writing one");

    flag_hold_a: assert property (err_reg && !(io_wr_i && hit_ctrl) |=> err_reg)
        else $error("error flag dropped without a clear");

    red_lamp_a: assert property (wr_ctrl |=> timeout_monitor_lamp_o == $past(io_wdata_i[CTRL_LAMP_BIT]))
        else $error("red watchdog lamp does not follow control bit 6");

    lamp_one_a: assert property (wr_lamp |=> first_user_lamp_yellow_o
            == ($past(io_wdata_i[LAMP1_HI]) && !$past(io_wdata_i[LAMP1_LO]))
            && first_user_lamp_green_o == !$past(io_wdata_i[LAMP1_HI]))
        else $error("first lamp colour wrong");

    lamp_two_a: assert property (!(second_user_lamp_red_o && second_user_lamp_yellow_o)
            && (second_user_lamp_red_o == !lamp_reg[LAMP2_HI]))
        else $error("second lamp colour wrong");

    lamp_three_a: assert property (!(third_user_lamp_red_o && third_user_lamp_yellow_o)
            && (third_user_lamp_yellow_o == (lamp_reg[LAMP3_HI] && !lamp_reg[LAMP3_LO])))
        else $error("third lamp colour wrong");

    batt_read_a: assert property (io_rd_i && hit_batt |=> io_rvalid_o
            && io_rdata_o == {8'h00, $past(batt_sync_reg), 6'h00})
        else $error("battery read returned wrong bits");

    ctrl_reset_a: assert property ($fell(sys_rst_i) |-> ctrl_reg[CTRL_SCALE_HI:CTRL_SCALE_LO] == 3'h0)
        else $error("scaler not at shortest timeout after reset");

    lamp_reset_a: assert property ($fell(sys_rst_i)
            |-> lamp_reg == LAMP_RESET)
        else $error("user lamps not dark after reset");

    alarm_reset_a: assert property ($fell(sys_rst_i)
            |-> !timeout_monitor_alarm_o && !timeout_monitor_lamp_o)
        else $error("alarm or red lamp set after reset");

    // bus answers: one-cycle valid, data held between reads
    rvalid_pulse_a: assert property (io_rvalid_o == $past(io_rd_i))
        else $error("read valid is not a one-cycle answer");

    rdata_hold_a: assert property (!io_rd_i |=> $stable(io_rdata_o))
        else $error("read data changed without a read");

    unmapped_zero_a: assert property (io_rd_i
            && !(hit_ctrl || hit_batt || hit_lamp) |=> io_rdata_o == 16'h0000)
        else $error("trigger or unmapped read returned data");

    ctrl_read_a: assert property (io_rd_i && hit_ctrl
            |=> io_rdata_o[CTRL_ERR_BIT] == $past(err_reg)
            && io_rdata_o[CTRL_LAMP_BIT:CTRL_EN_BIT] == $past(ctrl_reg[CTRL_LAMP_BIT:CTRL_EN_BIT]))
        else $error("control read does not show flag and settings");

    lamp_read_a: assert property (io_rd_i && hit_lamp |=> io_rdata_o == $past(lamp_reg))
        else $error("lamp read does not return the register");

    // stored settings change only on a write to their own port
    ctrl_store_a: assert property (wr_ctrl
            |=> ctrl_reg[CTRL_LAMP_BIT:CTRL_EN_BIT] == $past(io_wdata_i[CTRL_LAMP_BIT:CTRL_EN_BIT]))
        else $error("control write not stored");

    ctrl_hold_a: assert property (!wr_ctrl |=> $stable(ctrl_reg))
        else $error("control settings changed without a write");

    lamp_store_a: assert property (wr_lamp |=> lamp_reg == $past(io_wdata_i))
        else $error("lamp register did not take the written word");

    lamp_hold_a: assert property (!wr_lamp |=> $stable(lamp_reg))
        else $error("lamp register changed without a write");

    lamp_one_excl_a: assert property (!first_user_lamp_green_o
            || !first_user_lamp_yellow_o)
        else $error("first lamp green and yellow at once");

    // the countdown may only fire while enabled and left alone
    expire_gate_a: assert property (tmr.expired
            |-> $past(wd_enabled && !tmr.restart))
        else $error("expiry while disabled or just restarted");

    elapsed_bound_a: assert property (tmr.elapsed_ms < tmr.limit_ms)
        else $error("countdown ran past the selected timeout");

    err_rise_a: assert property (!err_reg && !tmr.expired |=> !err_reg)
        else $error("error flag rose without an expiry");

    mem_valid_a: assert property (mem_read_s |=> mem_rvalid_o)
        else $error("window read not answered next cycle");

    mem_idle_a: assert property (!(mem_sel_i && mem_rd_i) |=> !mem_rvalid_o)
        else $error("window answer without a read");

endmodule

//--- hw/wd_countdown.sv
/*
  Millisecond countdown for the watchdog: a prescaler makes 1 ms ticks.
  Assumes restart and run come from logic on the same clock.
*/
`timescale 1ns/1ps
module wd_countdown #(
    parameter int TICK_CYC = wdt_ports_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // control side
    wd_timer_if.timer tmr
);
    import wdt_ports_pkg::*;

    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);

    logic [PRE_W-1:0] pre_reg;
    ms_t ms_reg;
    logic exp_reg;
    wire tick = (pre_reg == PRE_LAST);
    wire hit = tick && (ms_reg == tmr.limit_ms - ms_t'(1));
    wire idle = tmr.restart || !tmr.run;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pre_reg <= '0;
            ms_reg <= '0;
            exp_reg <= 1'b0;
        end else begin
            pre_reg <= (idle || tick) ? '0 : pre_reg + 1'b1;
            ms_reg <= (idle || hit) ? '0 : (tick ? ms_reg + 1'b1 : ms_reg);
            exp_reg <= !idle && hit;
        end
    end

    assign tmr.elapsed_ms = ms_reg;
    assign tmr.expired = exp_reg;
endmodule

//--- hw/wd_timer_if.sv
/*
  Carrier between the port logic and its millisecond countdown.
  Assumes both ends sit on the same system clock.
*/
`timescale 1ns/1ps
interface wd_timer_if;
    import wdt_ports_pkg::*;
    logic run;
    logic restart;
    ms_t limit_ms;
    ms_t elapsed_ms;
    logic expired;
    modport ctrl (output run, output restart, output limit_ms,
                  input elapsed_ms, input expired);
    modport timer (input run, input restart, input limit_ms,
                   output elapsed_ms, output expired);
endinterface

//--- hw/wdt_ports_pkg.sv
/*
  Constants shared by the watchdog, lamp, battery and retained memory port logic.
  Assumes a 25 MHz system clock and host I/O cycles already decoded to strobes.
*/
// Notes on behaviour
// - control bit 0 enables the watchdog; 0 keeps it disabled.
// - bit 1 picks standard or macro time base; bits 5..3 pick one of eight timeouts.
// - after reset the scaler field is 000, the shortest timeout.
// - control bit 2 selects the trigger port; its value 0 is reserved. The code only stores it (reset 1); the trigger port stays 0x0066.
// - control bit 6 drives the red watchdog lamp directly.
// - bit 7 reads 1 after the watchdog fired; writing 1 clears it.
// - any read of the trigger port restarts the countdown; data is meaningless.
// - first lamp from bits 15 and 7: dark, yellow or green.
// - second lamp from bits 14 and 6: dark, red or yellow.
// - third lamp from bits 13 and 5: dark, red or yellow.
// - battery register bits 7..6 report sufficient, nearly exhausted or empty.
// - battery register is read-only three-level status; writes do nothing.
// - a 512 KB readable retained memory window; base assigned outside.
package wdt_ports_pkg;

    // host I/O port map
    localparam logic [15:0] ADDR_WDT_CTRL = 16'h0062;
    localparam logic [15:0] ADDR_WDT_TRIG = 16'h0066;
    localparam logic [15:0] ADDR_BATTERY = 16'h404D;
    localparam logic [15:0] ADDR_LAMPS = 16'h404E;

    // control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MACRO_BIT = 1;
    localparam int CTRL_SEL_BIT = 2;
    localparam int CTRL_SCALE_LO = 3;
    localparam int CTRL_SCALE_HI = 5;
    localparam int CTRL_LAMP_BIT = 6;
    localparam int CTRL_ERR_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h04;
    localparam logic [7:0] CTRL_STORE_MASK = 8'h7F;

    // lamp register fields
    localparam int LAMP1_HI = 15;
    localparam int LAMP1_LO = 7;
    localparam int LAMP2_HI = 14;
    localparam int LAMP2_LO = 6;
    localparam int LAMP3_HI = 13;
    localparam int LAMP3_LO = 5;
    localparam logic [15:0] LAMP_RESET = 16'hE0E0;

    // battery field
    localparam int BATT_LO = 6;
    localparam int BATT_HI = 7;

    // retained memory window
    localparam int NVM_BYTES = 32'h80000;
    localparam int NVM_ADDR_W = $clog2(NVM_BYTES);

    // time base
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int MS_PER_S = 1000;
    localparam int MS_W = 16;
    localparam int PRE_W = 16;

    typedef logic [MS_W-1:0] ms_t;
    typedef logic [2:0] scale_t;

    localparam ms_t STD_MS [8] = '{16'd94, 16'd210, 16'd340, 16'd460,
                                   16'd590, 16'd710, 16'd840, 16'd960};
    localparam ms_t MACRO_S [8] = '{16'd2, 16'd4, 16'd6, 16'd8,
                                    16'd16, 16'd32, 16'd48, 16'd64};

    function automatic ms_t timeout_ms(input logic macro, input scale_t sc);
        ms_t val;
        val = macro ? ms_t'(MACRO_S[sc] * MS_PER_S) : STD_MS[sc];
        return val;
    endfunction

endpackage
